//--- irq_flags_and_clock_select.sv
// interrupt flag register 1 and clock control register, apb slave
// assumes apb3 master on I_CLK, analog inputs asynchronous to I_CLK
//
// What this block does
// - comparator output trigger sets comparator pending flag
// - pwm period rollover sets pwm pending flag
// - supply below threshold sets low-voltage flag
// - write zero clears flag, one keeps it
// - fast type: zero internal rc, one crystal
// - fast halt bit stops fast clock, resets one
// - slow halt bit stops slow clock in sleep
// - source select: zero slow, one fast clock
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module irq_flags_and_clock_select
    import irqclk_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // event sources
    input wire logic I_CMP_OUT,
    input wire logic I_PWM_ROLL,
    input wire logic I_LOW_VOLT,
    input wire logic I_SLEEP_EXEC,
    input wire logic I_WAKE,
    // clock steering
    output logic O_SLOW_OSC_TYPE,
    output logic O_FAST_OSC_TYPE,
    output logic O_FAST_OSC_RUN,
    output logic O_SLOW_OSC_RUN,
    output logic O_SYSCLK_FAST,
    output logic O_IRQ
);

    // --------------------------------------------------------------
    // apb decode
    // --------------------------------------------------------------
    logic [5:0] idx;
    logic setup_phase;
    logic wr_stb;
    logic hit;

    // low address bits are ignored; masters issue aligned words
    assign idx = 6'(I_PADDR[ADDR_W-1:2]);
    assign setup_phase = I_PSEL & ~I_PENABLE;
    // a write lands at the single edge that closes the access phase
    assign wr_stb = I_PSEL & I_PENABLE & I_PWRITE;

    always_comb begin
        unique case (idx)
            IDX_INT_ENABLE_1,
            IDX_INT_FLAG_1,
            IDX_CLOCK_CONTROL,
            IDX_IRQ_STATUS,
            IDX_IRQ_MASK,
            IDX_CMP_TRIG: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // zero wait states: every access phase completes at once
    assign O_PREADY = I_PSEL & I_PENABLE;

    // --------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------
    logic [1:0] analog_s;
    logic cmp_s;
    logic lowv_s;

    // comparator and detector are analog, so they are resynchronised
    sync2 #(
        .W(2)
    ) u_sync (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_d({I_CMP_OUT, I_LOW_VOLT}),
        .o_q(analog_s)
    );

    assign cmp_s = analog_s[1];
    assign lowv_s = analog_s[0];

    // --------------------------------------------------------------
    // comparator trigger detection
    // --------------------------------------------------------------
    logic cmp_prev_ff;
    logic [1:0] cmp_trig_ff;
    logic cmp_rise;
    logic cmp_fall;
    logic cmp_hit;

    // previous sample, taken only from the synchronised level
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            cmp_prev_ff <= 1'b0;
        end else begin
            cmp_prev_ff <= cmp_s;
        end
    end

    assign cmp_rise = cmp_s & ~cmp_prev_ff;
    assign cmp_fall = ~cmp_s & cmp_prev_ff;

    // trigger select: rising, falling, or either edge
    always_comb begin
        if (cmp_trig_ff == TRIG_RISE) begin
            cmp_hit = cmp_rise;
        end else if (cmp_trig_ff == TRIG_FALL) begin
            cmp_hit = cmp_fall;
        end else begin
            cmp_hit = cmp_rise | cmp_fall;
        end
    end

    // trigger condition register
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            cmp_trig_ff <= RST_CMP_TRIG;
        end else if (wr_stb && idx == IDX_CMP_TRIG) begin
            cmp_trig_ff <= I_PWDATA[1:0];
        end
    end

    // --------------------------------------------------------------
    // event vector
    // --------------------------------------------------------------
    logic [NUM_EV-1:0] ev;

    always_comb begin
        ev = '0;
        ev[EV_CMP] = cmp_hit;
        ev[EV_PWM] = I_PWM_ROLL;
        // a level, so the flag re-arms while the supply stays low
        ev[EV_LOWV] = lowv_s;
    end

    // --------------------------------------------------------------
    // interrupt flag register 1 (write zero to clear)
    // --------------------------------------------------------------
    logic [NUM_EV-1:0] pend_clr;
    logic [NUM_EV-1:0] pend;
    logic flag_wr;

    assign flag_wr = wr_stb && idx == IDX_INT_FLAG_1;

    // a zero in a flag position clears it; a one leaves it alone
    always_comb begin
        pend_clr = '0;
        pend_clr[EV_CMP] = flag_wr & ~I_PWDATA[BIT_CMP];
        pend_clr[EV_PWM] = flag_wr & ~I_PWDATA[BIT_PWM];
        pend_clr[EV_LOWV] = flag_wr & ~I_PWDATA[BIT_LOWV];
    end

    pend_flags #(
        .W(NUM_EV)
    ) u_pend (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_set(ev),
        .i_clr(pend_clr),
        .o_flag(pend)
    );

    // --------------------------------------------------------------
    // interrupt enable register 1
    // --------------------------------------------------------------
    logic [7:0] int_en_ff;
    logic [7:0] nxt_int_en;

    // only the three enable positions are storage; the rest read zero
    always_comb begin
        nxt_int_en = 8'h00;
        nxt_int_en[BIT_CMP] = I_PWDATA[BIT_CMP];
        nxt_int_en[BIT_PWM] = I_PWDATA[BIT_PWM];
        nxt_int_en[BIT_LOWV] = I_PWDATA[BIT_LOWV];
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            int_en_ff <= RST_INT_ENABLE_1;
        end else if (wr_stb && idx == IDX_INT_ENABLE_1) begin
            int_en_ff <= nxt_int_en;
        end
    end

    // --------------------------------------------------------------
    // block interrupt status (write one to clear) and mask
    // --------------------------------------------------------------
    logic [NUM_EV-1:0] sts_clr;
    logic [NUM_EV-1:0] sts;
    logic [NUM_EV-1:0] mask_ff;
    logic [NUM_EV-1:0] en_vec;

    assign sts_clr = (wr_stb && idx == IDX_IRQ_STATUS) ? I_PWDATA[NUM_EV-1:0] : '0;

    pend_flags #(
        .W(NUM_EV)
    ) u_sts (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_set(ev),
        .i_clr(sts_clr),
        .o_flag(sts)
    );

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            mask_ff <= RST_IRQ_MASK;
        end else if (wr_stb && idx == IDX_IRQ_MASK) begin
            mask_ff <= I_PWDATA[NUM_EV-1:0];
        end
    end

    assign en_vec = {int_en_ff[BIT_CMP], int_en_ff[BIT_PWM], int_en_ff[BIT_LOWV]};

    // level request: pending flag with its enable, or unmasked status
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |((pend & en_vec) | (sts & mask_ff));
        end
    end

    // --------------------------------------------------------------
    // clock control register
    // --------------------------------------------------------------
    logic [7:0] clk_ctl_ff;
    logic [7:0] nxt_clk_ctl;

    // unimplemented positions are held at zero
    always_comb begin
        nxt_clk_ctl = 8'h00;
        nxt_clk_ctl[BIT_SLOW_TYPE] = I_PWDATA[BIT_SLOW_TYPE];
        nxt_clk_ctl[BIT_FAST_TYPE] = I_PWDATA[BIT_FAST_TYPE];
        nxt_clk_ctl[BIT_SLOW_HALT] = I_PWDATA[BIT_SLOW_HALT];
        nxt_clk_ctl[BIT_FAST_HALT] = I_PWDATA[BIT_FAST_HALT];
        nxt_clk_ctl[BIT_SYS_SEL] = I_PWDATA[BIT_SYS_SEL];
    end

    // reset leaves the fast oscillator halted and slow clock selected
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            clk_ctl_ff <= RST_CLOCK_CONTROL;
        end else if (wr_stb && idx == IDX_CLOCK_CONTROL) begin
            clk_ctl_ff <= nxt_clk_ctl;
        end
    end

    // --------------------------------------------------------------
    // sleep tracking
    // --------------------------------------------------------------
    pwr_state_t state_ff;
    pwr_state_t nxt_state;

    // wake wins over a simultaneous sleep so a wake is never lost
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (I_SLEEP_EXEC && !I_WAKE) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (I_WAKE) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // --------------------------------------------------------------
    // oscillator steering outputs
    // --------------------------------------------------------------
    // registered so the analog enables never glitch on decode
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_SLOW_OSC_TYPE <= 1'b0;
            O_FAST_OSC_TYPE <= 1'b0;
            O_FAST_OSC_RUN <= 1'b0;
            O_SLOW_OSC_RUN <= 1'b1;
            O_SYSCLK_FAST <= 1'b0;
        end else begin
            O_SLOW_OSC_TYPE <= clk_ctl_ff[BIT_SLOW_TYPE];
            O_FAST_OSC_TYPE <= clk_ctl_ff[BIT_FAST_TYPE];
            O_FAST_OSC_RUN <= ~clk_ctl_ff[BIT_FAST_HALT];
            O_SLOW_OSC_RUN <= ~(clk_ctl_ff[BIT_SLOW_HALT] & (state_ff == ST_SLEEP));
            O_SYSCLK_FAST <= clk_ctl_ff[BIT_SYS_SEL];
        end
    end

    // --------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------
    logic [7:0] rd_val;
    logic [7:0] pend_view;

    // pending flags shown at their register positions
    always_comb begin
        pend_view = 8'h00;
        pend_view[BIT_CMP] = pend[EV_CMP];
        pend_view[BIT_PWM] = pend[EV_PWM];
        pend_view[BIT_LOWV] = pend[EV_LOWV];
    end

    always_comb begin
        rd_val = 8'h00;
        unique case (idx)
            IDX_INT_ENABLE_1: rd_val = int_en_ff;
            IDX_INT_FLAG_1: rd_val = pend_view;
            IDX_CLOCK_CONTROL: rd_val = clk_ctl_ff;
            IDX_IRQ_STATUS: rd_val = {5'h00, sts};
            IDX_IRQ_MASK: rd_val = {5'h00, mask_ff};
            IDX_CMP_TRIG: rd_val = {6'h00, cmp_trig_ff};
            default: rd_val = 8'h00;
        endcase
    end

    // --------------------------------------------------------------
    // response registers
    // --------------------------------------------------------------
    // data captured in the setup cycle, held through the access phase;
    // a flag that sets during the access cycle shows on the next read
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else if (setup_phase) begin
            O_PRDATA <= {24'h00_0000, I_PWRITE ? 8'h00 : rd_val};
            O_PSLVERR <= ~hit;
        end
    end

endmodule // irq_flags_and_clock_select

//--- irqclk_chk.sv
// concurrent checks on the port behaviour of the flag and clock-select slice
// assumes binding into irq_flags_and_clock_select, one clock, sync reset
`timescale 1ns/1ps
module irqclk_chk
    import irqclk_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic I_SLEEP_EXEC,
    input wire logic I_WAKE,
    input wire logic O_SLOW_OSC_TYPE,
    input wire logic O_FAST_OSC_TYPE,
    input wire logic O_FAST_OSC_RUN,
    input wire logic O_SLOW_OSC_RUN,
    input wire logic O_SYSCLK_FAST,
    input wire logic O_IRQ
);
    // request decode; only the word index matters, low address bits are ignored
    logic [5:0] idx;
    logic wr_clk;
    logic mapped;
    assign idx = 6'(I_PADDR[ADDR_W-1:2]);
    assign wr_clk = I_PSEL && I_PENABLE && I_PWRITE && (idx == IDX_CLOCK_CONTROL);
    assign mapped = idx inside {IDX_INT_ENABLE_1, IDX_INT_FLAG_1, IDX_CLOCK_CONTROL,
        IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_CMP_TRIG};

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SRST);

    // clock outputs take effect two edges after the write (register, then output flop)
    chk_reset_clocks: assert property ($fell(I_SRST) |-> !O_FAST_OSC_RUN
        && O_SLOW_OSC_RUN && !O_SYSCLK_FAST && !O_FAST_OSC_TYPE && !O_SLOW_OSC_TYPE)
        else $error("clock outputs not at reset values");
    chk_fast_type: assert property (wr_clk |-> ##2
        O_FAST_OSC_TYPE == $past(I_PWDATA[BIT_FAST_TYPE], 2)) else $error("fast type wrong");
    chk_fast_halt: assert property (wr_clk |-> ##2
        O_FAST_OSC_RUN == !$past(I_PWDATA[BIT_FAST_HALT], 2)) else $error("fast run wrong");
    chk_sys_select: assert property (wr_clk |-> ##2
        O_SYSCLK_FAST == $past(I_PWDATA[BIT_SYS_SEL], 2)) else $error("sysclk select wrong");
    chk_slow_type: assert property (wr_clk |-> ##2
        O_SLOW_OSC_TYPE == $past(I_PWDATA[BIT_SLOW_TYPE], 2)) else $error("slow type wrong");
    chk_slow_stop: assert property ($fell(O_SLOW_OSC_RUN) |->
        $past(I_SLEEP_EXEC, 2) || $past(wr_clk, 2)) else $error("slow clock stopped unasked");
    chk_slow_resume: assert property ($rose(O_SLOW_OSC_RUN) |->
        $past(I_WAKE, 2) || $past(wr_clk, 2) || $past(I_SRST, 2))
        else $error("slow clock restarted unasked");
    chk_ready_zero_wait: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
        else $error("no ready in access cycle");
    chk_slverr_map: assert property (I_PSEL && !I_PENABLE |=> O_PSLVERR == !$past(mapped))
        else $error("slave error does not match decode");

    cover property ($rose(O_IRQ));
    cover property ($fell(O_SLOW_OSC_RUN));
    cover property (O_PSLVERR && O_PREADY);
endmodule // irqclk_chk

bind irq_flags_and_clock_select irqclk_chk #(.ADDR_W(ADDR_W)) u_chk (.I_CLK(I_CLK),
    .I_SRST(I_SRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_SLEEP_EXEC(I_SLEEP_EXEC), .I_WAKE(I_WAKE), .O_SLOW_OSC_TYPE(O_SLOW_OSC_TYPE),
    .O_FAST_OSC_TYPE(O_FAST_OSC_TYPE), .O_FAST_OSC_RUN(O_FAST_OSC_RUN),
    .O_SLOW_OSC_RUN(O_SLOW_OSC_RUN), .O_SYSCLK_FAST(O_SYSCLK_FAST), .O_IRQ(O_IRQ));

//--- irqclk_pkg.sv
// constants for the interrupt-flag and clock-select register slice
// assumes an apb slave with 32-bit data, register index = byte address / 4
package irqclk_pkg;

    // --------------------------------------------------------------
    // register indices (byte address is four times the index)
    // --------------------------------------------------------------
    localparam logic [5:0] IDX_INT_ENABLE_1 = 6'h0D;
    localparam logic [5:0] IDX_INT_FLAG_1 = 6'h0E;
    localparam logic [5:0] IDX_CLOCK_CONTROL = 6'h0F;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
    localparam logic [5:0] IDX_CMP_TRIG = 6'h22;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int BIT_CMP = 4;
    localparam int BIT_PWM = 1;
    localparam int BIT_LOWV = 0;
    localparam int BIT_SLOW_TYPE = 7;
    localparam int BIT_FAST_TYPE = 6;
    localparam int BIT_SLOW_HALT = 4;
    localparam int BIT_FAST_HALT = 3;
    localparam int BIT_SYS_SEL = 2;

    // event vector order: [2] comparator, [1] pwm, [0] low voltage
    localparam int EV_CMP = 2;
    localparam int EV_PWM = 1;
    localparam int EV_LOWV = 0;
    localparam int NUM_EV = 3;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RST_INT_ENABLE_1 = 8'h00;
    localparam logic [7:0] RST_CLOCK_CONTROL = 8'h08;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;
    localparam logic [1:0] RST_CMP_TRIG = 2'h0;

    // comparator trigger condition codes
    localparam logic [1:0] TRIG_RISE = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;

    // sleep tracking states, one-hot
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_SLEEP = 2'b10
    } pwr_state_t;

endpackage

//--- pend_flags.sv
// a row of sticky pending bits: hardware sets, software clears
// assumes set and clear are one-cycle strobes on the same clock
`timescale 1ns/1ps
module pend_flags #(
    parameter int W = 3
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_flag
);
    // --------------------------------------------------------------
    // one flop per bit
    // --------------------------------------------------------------
    for (genvar g = 0; g < W; g++) begin : g_bit
        logic nxt_flag;
        // set beats clear so an event in the clearing cycle survives
        assign nxt_flag = i_set[g] | (o_flag[g] & ~i_clr[g]);
        always_ff @(posedge i_clk) begin
            if (i_srst) begin
                o_flag[g] <= 1'b0;
            end else begin
                o_flag[g] <= nxt_flag;
            end
        end
    end
endmodule // pend_flags

//--- sync2.sv
// two-flop synchroniser for levels arriving from outside the clock domain
// assumes each bit is an independent slow level
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_ff;

    // first stage is read only by the second stage
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_ff <= '0;
            o_q <= '0;
        end else begin
            meta_ff <= i_d;
            o_q <= meta_ff;
        end
    end
endmodule // sync2

//--- tb.sv
// self-checking bench for the flag and clock-select slice over apb
// assumes zero-wait slave; waits are bounded only by the cycle ceiling
`timescale 1ns/1ps
module tb
    import irqclk_pkg::*;
;
    localparam logic [7:0] A_EN = {IDX_INT_ENABLE_1, 2'b00};
    localparam logic [7:0] A_FLAG = {IDX_INT_FLAG_1, 2'b00};
    localparam logic [7:0] A_CLK = {IDX_CLOCK_CONTROL, 2'b00};
    localparam logic [7:0] A_STAT = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] A_TRIG = {IDX_CMP_TRIG, 2'b00};
    logic clk, srst, psel, penable, pwrite, cmp, pwm, lowv, sleep, wake;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic pready, pslverr, slow_type, fast_type, fast_run, slow_run, sys_fast, irq, errv;
    int bad_count, tests_run, cyc;

    irq_flags_and_clock_select DUT (.I_CLK(clk), .I_SRST(srst), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CMP_OUT(cmp),
        .I_PWM_ROLL(pwm), .I_LOW_VOLT(lowv), .I_SLEEP_EXEC(sleep), .I_WAKE(wake),
        .O_SLOW_OSC_TYPE(slow_type), .O_FAST_OSC_TYPE(fast_type), .O_FAST_OSC_RUN(fast_run),
        .O_SLOW_OSC_RUN(slow_run), .O_SYSCLK_FAST(sys_fast), .O_IRQ(irq));

    // 50 ns period
    always #25 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one apb transfer; an idle edge first, so back-to-back calls never clash
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        check(rdv, exp, what);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    // outputs order: slow type, fast type, fast run, sysclk fast, slow run
    task automatic clk_case(input logic [31:0] d, input logic [31:0] exp, input logic [4:0] o);
        wr(A_CLK, d);
        rd(A_CLK, exp, "clock control readback");
        check(32'({slow_type, fast_type, fast_run, sys_fast, slow_run}), 32'(o), "clock outs");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        {clk, psel, penable, pwrite, cmp, pwm, lowv, sleep, wake} = 9'h000;
        srst = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd(A_EN, 32'h0, "enable reset");
        rd(A_FLAG, 32'h0, "flag reset");
        rd(A_CLK, 32'h08, "clock control reset");
        rd(A_STAT, 32'h0, "status reset");
        rd(A_MASK, 32'h0, "mask reset");
        rd(A_TRIG, 32'h0, "trigger reset");
        $display("done: reset values");
        clk_case(32'hFF, 32'hDC, 5'b11011);
        clk_case(32'h00, 32'h00, 5'b00101);
        $display("done: clock control");
        for (int h = 0; h < 2; h++) begin
            wr(A_CLK, h ? 32'h10 : 32'h00);
            @(posedge clk) sleep <= 1'b1;
            @(posedge clk) sleep <= 1'b0;
            step(2);
            check(32'(slow_run), 32'(h == 0), "slow clock in sleep");
            @(posedge clk) wake <= 1'b1;
            @(posedge clk) wake <= 1'b0;
            step(2);
            check(32'(slow_run), 32'h1, "slow clock after wake");
        end
        $display("done: sleep");
        wr(A_EN, 32'h02);
        @(posedge clk) pwm <= 1'b1;
        @(posedge clk) pwm <= 1'b0;
        step(2);
        check(32'(irq), 32'h1, "irq on enabled pwm flag");
        rd(A_FLAG, 32'h02, "pwm flag set");
        wr(A_FLAG, 32'hFF);
        rd(A_FLAG, 32'h02, "write one keeps flag");
        wr(A_FLAG, 32'hFD);
        rd(A_FLAG, 32'h00, "write zero clears flag");
        check(32'(irq), 32'h0, "irq gone after clear");
        rd(A_STAT, 32'h02, "status sticky");
        wr(A_EN, 32'h00);
        wr(A_STAT, 32'h02);
        @(posedge clk) pwm <= 1'b1;
        @(posedge clk) pwm <= 1'b0;
        step(2);
        check(32'(irq), 32'h0, "irq masked");
        wr(A_MASK, 32'h02);
        step(2);
        check(32'(irq), 32'h1, "irq unmasked");
        wr(A_STAT, 32'h02);
        wr(A_FLAG, 32'h00);
        step(2);
        check(32'(irq), 32'h0, "irq cleared");
        wr(A_MASK, 32'h00);
        $display("done: pwm and interrupt");
        @(posedge clk) lowv <= 1'b1;
        step(4);
        wr(A_FLAG, 32'hFE);
        rd(A_FLAG, 32'h01, "low volt flag re-sets while low");
        @(posedge clk) lowv <= 1'b0;
        step(4);
        wr(A_FLAG, 32'hFE);
        rd(A_FLAG, 32'h00, "low volt flag cleared");
        $display("done: low voltage");
        // codes 2 and 3 both mean either edge, so all four are walked
        for (int t = 0; t < 4; t++) begin
            wr(A_TRIG, 32'(t));
            wr(A_FLAG, 32'h00);
            @(posedge clk) cmp <= 1'b1;
            step(6);
            rd(A_FLAG, (t != 1) ? 32'h10 : 32'h00, "comparator rising");
            wr(A_FLAG, 32'h00);
            @(posedge clk) cmp <= 1'b0;
            step(6);
            rd(A_FLAG, (t != 0) ? 32'h10 : 32'h00, "comparator falling");
        end
        $display("done: comparator");
        wr(8'h40, 32'hFF);
        check(32'(errv), 32'h1, "unmapped write error");
        rd(8'h40, 32'h0, "unmapped read");
        check(32'(errv), 32'h1, "unmapped read error");
        rd(A_EN, 32'h0, "enable untouched");
        check(32'(errv), 32'h0, "mapped no error");
        $display("done: unmapped");
        results();
    end
endmodule // tb
